// [rtl/scmc_map.vh]
// Register map, field positions, reset values and encodings for the clock mode control
// How it works
// - Bit 0 of the mode register picks the system clock, 0 for the fast crystal (default) and 1 for the 32768 Hz oscillator.
// - Once slow is requested the system clock runs from the 32768 Hz oscillator and the fast oscillator is shut off unless bit 1 is set.
// - Going from slow to fast moves the clock to the fast oscillator while the slow one keeps running.
// - Bit 1 enables the fast oscillator and hardware clears it when the source changes from slow to fast.
// - Bit 2 at 1 disables the slow oscillator, at 0 enables it, enabled by default.
// - Bits 5:4 choose the timer 1 prescaler source: 00 slow clock, 01 system clock over 4, 10 watchdog oscillator, 11 none.
// - Bit 6 chooses the timer 1 clock, 0 for system clock over 4 (default) and 1 for the prescaler output.
// - Bit 7 enables slow oscillator quick start, is set at power-on and may be cleared by software.
// - Power-down stops the fast oscillator.
// - The enabled slow oscillator keeps running at all times, power-down included.
// - The fast clock is 6 or 12 MHz, 12 MHz by default, and software sets the rate select bit to match.
// - The watchdog oscillator keeps running in power-down unless the option disables it.
// - Bit 3 is a read-only low-supply flag, 1 when the supply is below the detect level.
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCMC_OFS_MODE      12'h040
`define SCMC_OFS_CONFIG    12'h044
`define SCMC_OFS_IRQ_STAT  12'h048
`define SCMC_OFS_IRQ_MASK  12'h04C
`define SCMC_ADDR_W        12

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define SCMC_B_SRC         0
`define SCMC_B_FAST_EN     1
`define SCMC_B_SLOW_DIS    2
`define SCMC_B_LOW_SUPPLY  3
`define SCMC_B_PSS_LSB     4
`define SCMC_B_PSS_MSB     5
`define SCMC_B_T1_SEL      6
`define SCMC_B_QUICK       7
`define SCMC_MODE_RESET    8'h80
`define SCMC_MODE_WMASK    8'hF7

// Config register: bit 0 fast rate select (1 = 12 MHz), bit 1 watchdog osc option enable
`define SCMC_B_RATE_12M    0
`define SCMC_B_WDT_OPT     1
`define SCMC_CFG_RESET     2'b11

// Prescaler source codes
`define SCMC_PSS_RTC       2'b00
`define SCMC_PSS_SYS4      2'b01
`define SCMC_PSS_WDT       2'b10
`define SCMC_PSS_NONE      2'b11

// Interrupt status bits
`define SCMC_IRQ_W         3
`define SCMC_EV_TO_SLOW    0
`define SCMC_EV_TO_FAST    1
`define SCMC_EV_LOW_SUP    2

// Clock tree state encodings (one-hot)
`define SCMC_ST_FAST       3'b001
`define SCMC_ST_SWITCH     3'b010
`define SCMC_ST_SLOW       3'b100

// Synchronisation depth for the glitch-free multiplexer
`define SCMC_MUX_SYNC      2

`endif

// [rtl/scmc_sync2.v]
// Two flip-flop level synchroniser
`default_nettype none
module scmc_sync2
(
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	input  wire pclk_en,
	// Level
	input  wire d_async,
	output reg  q_sync
);
	reg meta_q;

	// First stage is read only by the second
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 1'b0;
			q_sync <= 1'b0;
		end
		else if (pclk_en)
		begin
			meta_q <= d_async;
			q_sync <= meta_q;
		end
	end
endmodule // scmc_sync2
`default_nettype wire

// [rtl/scmc_glitch_mux.v]
// Glitch-free two-input clock select with cross-coupled enables
`default_nettype none
`include "scmc_map.vh"
module scmc_glitch_mux
(
	// Clocks
	input  wire clk_fast,
	input  wire clk_slow,
	input  wire rst_n,
	// Selection: 1 picks the slow clock
	input  wire sel_slow,
	// Output clock and state
	output wire clk_out,
	output wire fast_on,
	output wire slow_on
);
	reg [`SCMC_MUX_SYNC-1:0] fast_sync_q;
	reg [`SCMC_MUX_SYNC-1:0] slow_sync_q;
	reg                      fast_gate_q;
	reg                      slow_gate_q;

	// Each side enables only after the other side's last sync stage has dropped
	always @(posedge clk_fast or negedge rst_n)
	begin
		if (!rst_n)
			fast_sync_q <= {`SCMC_MUX_SYNC{1'b0}};
		else
			fast_sync_q <= {fast_sync_q[0], ~sel_slow & ~slow_sync_q[`SCMC_MUX_SYNC-1]};
	end

	always @(posedge clk_slow or negedge rst_n)
	begin
		if (!rst_n)
			slow_sync_q <= {`SCMC_MUX_SYNC{1'b0}};
		else
			slow_sync_q <= {slow_sync_q[0], sel_slow & ~fast_sync_q[`SCMC_MUX_SYNC-1]};
	end

	// Gate enables change on the falling edge so no runt high phase leaks out
	always @(negedge clk_fast or negedge rst_n)
	begin
		if (!rst_n)
			fast_gate_q <= 1'b0;
		else
			fast_gate_q <= fast_sync_q[`SCMC_MUX_SYNC-1];
	end

	always @(negedge clk_slow or negedge rst_n)
	begin
		if (!rst_n)
			slow_gate_q <= 1'b0;
		else
			slow_gate_q <= slow_sync_q[`SCMC_MUX_SYNC-1];
	end

	assign clk_out = (clk_fast & fast_gate_q) | (clk_slow & slow_gate_q);
	assign fast_on = fast_gate_q;
	assign slow_on = slow_gate_q;
endmodule // scmc_glitch_mux
`default_nettype wire

// [rtl/scmc_top.v]
// Clock mode control: mode register, APB slave, oscillator enables and clock select
`default_nettype none
`include "scmc_map.vh"
module scmc_top
(
	// APB slave
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    pclk_en,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [`SCMC_ADDR_W-1:0] paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output reg                     pready,
	output reg                     pslverr,
	// Oscillator and power-down inputs (asynchronous)
	input  wire                    clk_fast_osc,
	input  wire                    clk_slow_osc,
	input  wire                    clk_wdt_osc,
	input  wire                    power_down,
	input  wire                    low_supply_in,
	// Oscillator enables and selections
	output reg                     fast_osc_en,
	output reg                     slow_osc_en,
	output reg                     slow_osc_quick_start,
	output reg                     wdt_osc_en,
	output reg                     sys_sel_slow,
	output reg                     fast_clock_rate_select,
	output reg  [1:0]              timer1_prescaler_source,
	output reg                     timer1_clock_select,
	output reg                     timer1_prescaler_clk,
	output reg                     sys_clk_is_slow,
	output reg                     irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [7:0]               mode_q;
	reg  [1:0]               cfg_q;
	reg  [`SCMC_IRQ_W-1:0]   stat_q;
	reg  [`SCMC_IRQ_W-1:0]   stat_d;
	reg  [`SCMC_IRQ_W-1:0]   mask_q;
	reg  [2:0]               st_q;
	reg  [2:0]               st_d;
	reg                      low_prev_q;
	reg                      sys4_q;
	reg  [1:0]               div_q;
	wire                     pd_s;
	wire                     low_s;
	wire                     slow_on_s;
	wire                     fast_on_s;
	wire                     slow_tick_s;
	wire                     wdt_tick_s;
	wire                     clk_sys_unused;
	wire                     slow_on_raw;
	wire                     fast_on_raw;
	wire                     wr_en;
	wire                     rd_en;
	wire                     hit_mode;
	wire                     hit_cfg;
	wire                     hit_stat;
	wire                     hit_mask;
	wire [7:0]               mode_rd;
	wire                     ev_slow;
	wire                     ev_fast;
	wire                     ev_low;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	scmc_sync2 u_sync_pd (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(power_down), .q_sync(pd_s));
	scmc_sync2 u_sync_low (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(low_supply_in), .q_sync(low_s));
	scmc_sync2 u_sync_son (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(slow_on_raw), .q_sync(slow_on_s));
	scmc_sync2 u_sync_fon (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(fast_on_raw), .q_sync(fast_on_s));
	scmc_sync2 u_sync_stk (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(clk_slow_osc), .q_sync(slow_tick_s));
	scmc_sync2 u_sync_wtk (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.d_async(clk_wdt_osc), .q_sync(wdt_tick_s));

	// Glitch-free system clock select; the muxed clock ends on clk_sys_unused and does not leave the block
	scmc_glitch_mux u_mux (
		.clk_fast (clk_fast_osc),
		.clk_slow (clk_slow_osc),
		.rst_n    (presetn),
		.sel_slow (mode_q[`SCMC_B_SRC]),
		.clk_out  (clk_sys_unused),
		.fast_on  (fast_on_raw),
		.slow_on  (slow_on_raw)
	);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign wr_en    = psel & penable & pwrite & pready;
	assign rd_en    = psel & penable & ~pwrite & pready;
	assign hit_mode = (paddr == `SCMC_OFS_MODE);
	assign hit_cfg  = (paddr == `SCMC_OFS_CONFIG);
	assign hit_stat = (paddr == `SCMC_OFS_IRQ_STAT);
	assign hit_mask = (paddr == `SCMC_OFS_IRQ_MASK);

	// Low-supply bit is not stored: it shows the synchronised detector
	assign mode_rd = {mode_q[7:4], low_s, mode_q[2:0]};

	// One-cycle access phase: ready rises in the first access cycle, low otherwise
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else if (pclk_en)
			pready <= psel & ~penable;
	end

	// Read data and error answer are registered with ready
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (pclk_en)
		begin
			pslverr <= psel & ~penable & ~(hit_mode | hit_cfg | hit_stat | hit_mask);
			if (psel & ~penable & ~pwrite)
			begin
				if (hit_mode)
					prdata <= {24'h00_0000, mode_rd};
				else if (hit_cfg)
					prdata <= {30'h0000_0000, cfg_q};
				else if (hit_stat)
					prdata <= {29'h0000_0000, stat_q};
				else if (hit_mask)
					prdata <= {29'h0000_0000, mask_q};
				else
					prdata <= 32'h0000_0000;
			end
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Mode and config registers
	// ----------------------------------------
	// Source change from slow to fast clears the fast enable bit
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= `SCMC_MODE_RESET;
			cfg_q  <= `SCMC_CFG_RESET;
		end
		else if (pclk_en)
		begin
			if (wr_en & hit_mode)
			begin
				mode_q <= pwdata[7:0] & `SCMC_MODE_WMASK;
				if (mode_q[`SCMC_B_SRC] & ~pwdata[`SCMC_B_SRC])
					mode_q[`SCMC_B_FAST_EN] <= 1'b0;
			end
			if (wr_en & hit_cfg)
				cfg_q <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Clock tree state
	// ----------------------------------------
	// The switch state lasts until the mux reports the new side live
	always @*
	begin
		st_d = st_q;
		case (st_q)
			`SCMC_ST_FAST:
				if (mode_q[`SCMC_B_SRC])
					st_d = `SCMC_ST_SWITCH;
			`SCMC_ST_SWITCH:
				if (mode_q[`SCMC_B_SRC] & slow_on_s)
					st_d = `SCMC_ST_SLOW;
				else if (~mode_q[`SCMC_B_SRC] & fast_on_s)
					st_d = `SCMC_ST_FAST;
			`SCMC_ST_SLOW:
				if (~mode_q[`SCMC_B_SRC])
					st_d = `SCMC_ST_SWITCH;
			default:
				st_d = `SCMC_ST_FAST;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= `SCMC_ST_FAST;
		else if (pclk_en)
			st_q <= st_d;
	end

	// ----------------------------------------
	// Oscillator enables
	// ----------------------------------------
	// Fast osc off in slow mode unless software re-enables it, and off in power-down
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fast_osc_en          <= 1'b1;
			slow_osc_en          <= 1'b1;
			slow_osc_quick_start <= 1'b1;
			wdt_osc_en           <= 1'b1;
			sys_sel_slow         <= 1'b0;
			sys_clk_is_slow      <= 1'b0;
		end
		else if (pclk_en)
		begin
			// Fast osc stays up until the mux has left it, so the last edge is clean
			fast_osc_en <= ~pd_s & (~mode_q[`SCMC_B_SRC] | mode_q[`SCMC_B_FAST_EN]
				| ~st_q[2]);
			// Power-down has no term here: the slow osc runs whenever enabled
			slow_osc_en          <= ~mode_q[`SCMC_B_SLOW_DIS];
			slow_osc_quick_start <= mode_q[`SCMC_B_QUICK];
			wdt_osc_en           <= cfg_q[`SCMC_B_WDT_OPT];
			sys_sel_slow         <= mode_q[`SCMC_B_SRC];
			sys_clk_is_slow      <= st_q[2];
		end
	end

	// ----------------------------------------
	// Timer 1 clock selection
	// ----------------------------------------
	// System clock over 4 as a one-cycle tick
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q  <= 2'b00;
			sys4_q <= 1'b0;
		end
		else if (pclk_en)
		begin
			div_q  <= div_q + 2'b01;
			sys4_q <= (div_q == 2'b11);
		end
	end

	// Prescaler source decode and timer clock select
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer1_prescaler_source <= `SCMC_PSS_RTC;
			timer1_clock_select     <= 1'b0;
			timer1_prescaler_clk    <= 1'b0;
			fast_clock_rate_select  <= 1'b1;
		end
		else if (pclk_en)
		begin
			timer1_prescaler_source <= mode_q[`SCMC_B_PSS_MSB:`SCMC_B_PSS_LSB];
			timer1_clock_select     <= mode_q[`SCMC_B_T1_SEL];
			fast_clock_rate_select  <= cfg_q[`SCMC_B_RATE_12M];
			case (mode_q[`SCMC_B_PSS_MSB:`SCMC_B_PSS_LSB])
				`SCMC_PSS_RTC:  timer1_prescaler_clk <= slow_tick_s;
				`SCMC_PSS_SYS4: timer1_prescaler_clk <= sys4_q;
				`SCMC_PSS_WDT:  timer1_prescaler_clk <= wdt_tick_s;
				`SCMC_PSS_NONE: timer1_prescaler_clk <= 1'b0;
				default:        timer1_prescaler_clk <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign ev_slow = (st_q == `SCMC_ST_SWITCH) & (st_d == `SCMC_ST_SLOW);
	assign ev_fast = (st_q == `SCMC_ST_SWITCH) & (st_d == `SCMC_ST_FAST);
	assign ev_low  = low_s & ~low_prev_q;

	// Read clears, but an event in the same cycle wins
	always @*
	begin
		stat_d = stat_q;
		if (rd_en & hit_stat)
			stat_d = {`SCMC_IRQ_W{1'b0}};
		stat_d[`SCMC_EV_TO_SLOW] = stat_d[`SCMC_EV_TO_SLOW] | ev_slow;
		stat_d[`SCMC_EV_TO_FAST] = stat_d[`SCMC_EV_TO_FAST] | ev_fast;
		stat_d[`SCMC_EV_LOW_SUP] = stat_d[`SCMC_EV_LOW_SUP] | ev_low;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_q     <= {`SCMC_IRQ_W{1'b0}};
			mask_q     <= {`SCMC_IRQ_W{1'b0}};
			low_prev_q <= 1'b0;
			irq        <= 1'b0;
		end
		else if (pclk_en)
		begin
			stat_q     <= stat_d;
			low_prev_q <= low_s;
			if (wr_en & hit_mask)
				mask_q <= pwdata[`SCMC_IRQ_W-1:0];
			irq <= |(stat_d & mask_q);
		end
	end
endmodule // scmc_top
`default_nettype wire

// [sim/scmc_assertions.sv]
// Port-level checker for the clock mode control
`default_nettype none
`include "scmc_map.vh"
module scmc_checker
(
	// Bus side
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    pclk_en,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [`SCMC_ADDR_W-1:0] paddr,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	// Clock control side
	input wire logic                    power_down,
	input wire logic                    fast_osc_en,
	input wire logic                    slow_osc_en,
	input wire logic                    slow_osc_quick_start,
	input wire logic                    wdt_osc_en,
	input wire logic                    sys_sel_slow,
	input wire logic                    fast_clock_rate_select,
	input wire logic [1:0]              timer1_prescaler_source,
	input wire logic                    timer1_clock_select,
	input wire logic                    sys_clk_is_slow
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking dclk @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	wire mapped = (paddr == `SCMC_OFS_MODE) || (paddr == `SCMC_OFS_CONFIG)
		|| (paddr == `SCMC_OFS_IRQ_STAT) || (paddr == `SCMC_OFS_IRQ_MASK);
	wire rd_mode = pready && !pwrite && (paddr == `SCMC_OFS_MODE);
	wire rd_cfg  = pready && !pwrite && (paddr == `SCMC_OFS_CONFIG);
	wire wr_done = pready && pwrite;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	pready_pulse_a: assert property (psel && !penable && pclk_en |=> pready)
		else $error("no answer after setup cycle");
	pready_once_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_map_a: assert property (pready |-> pslverr == !mapped)
		else $error("error response does not match decode");
	mode_view_a: assert property (rd_mode |-> prdata[0] == sys_sel_slow
		&& prdata[2] == !slow_osc_en && prdata[7] == slow_osc_quick_start)
		else $error("mode bits differ from outputs");
	timer_view_a: assert property (rd_mode |-> prdata[5:4] == timer1_prescaler_source
		&& prdata[6] == timer1_clock_select)
		else $error("timer fields differ from outputs");
	cfg_view_a: assert property (rd_cfg |-> prdata[1:0] == {wdt_osc_en, fast_clock_rate_select})
		else $error("config bits differ from outputs");
	slow_entry_a: assert property ($rose(sys_clk_is_slow) |-> sys_sel_slow)
		else $error("slow clock entered without request");
	fast_hold_a: assert property ((!sys_sel_slow && !power_down && pclk_en) [*5] |-> fast_osc_en)
		else $error("fast oscillator off while selected");
	pd_stop_a: assert property ((power_down && pclk_en) [*5] |-> !fast_osc_en)
		else $error("fast oscillator runs in power-down");
	slow_keep_a: assert property ($changed(slow_osc_en) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("slow oscillator enable moved without a write");
endmodule // scmc_checker

bind scmc_top scmc_checker scmc_checker_i (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .power_down(power_down), .fast_osc_en(fast_osc_en),
	.slow_osc_en(slow_osc_en), .slow_osc_quick_start(slow_osc_quick_start),
	.wdt_osc_en(wdt_osc_en), .sys_sel_slow(sys_sel_slow),
	.fast_clock_rate_select(fast_clock_rate_select),
	.timer1_prescaler_source(timer1_prescaler_source),
	.timer1_clock_select(timer1_clock_select), .sys_clk_is_slow(sys_clk_is_slow));
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the clock mode control
`default_nettype none
`include "scmc_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                    pclk, presetn, pclk_en, psel, penable, pwrite;
	logic [`SCMC_ADDR_W-1:0] paddr;
	logic [31:0]             pwdata, prdata;
	logic                    pready, pslverr, osc_f, osc_s, osc_w, power_down, low_sup;
	logic                    f_en, s_en, quick, w_en, sel, rate, t1sel, is_slow, irq, t1clk;
	logic [1:0]              pss;
	logic [32:0]             exp_q[$];
	logic [31:0]             seed = 32'h0000_0042;
	int                      n_fail = 0;
	int                      cmp_count = 0;
	// Packed view: fast, slow, quick, wdt, sel, rate, pss, t1sel, is_slow, irq
	wire  [10:0]             outs = {f_en, s_en, quick, w_en, sel, rate, pss, t1sel, is_slow, irq};

	scmc_top scmc_top_i (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clk_fast_osc(osc_f), .clk_slow_osc(osc_s),
		.clk_wdt_osc(osc_w), .power_down(power_down), .low_supply_in(low_sup),
		.fast_osc_en(f_en), .slow_osc_en(s_en), .slow_osc_quick_start(quick),
		.wdt_osc_en(w_en), .sys_sel_slow(sel), .fast_clock_rate_select(rate),
		.timer1_prescaler_source(pss), .timer1_clock_select(t1sel),
		.timer1_prescaler_clk(t1clk), .sys_clk_is_slow(is_slow), .irq(irq));

	// Bus clock and free-running oscillators with unrelated periods
	initial begin pclk = 0; forever #5 pclk = ~pclk; end
	initial begin osc_f = 0; forever #21 osc_f = ~osc_f; end
	initial begin osc_s = 0; forever #157 osc_s = ~osc_s; end
	initial begin osc_w = 0; forever #400 osc_w = ~osc_w; end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; upper write bits carry random filler the block must ignore
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		exp_q.push_back(e);
		seed = xs(seed);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= w ? (d | (seed & 32'hFFFF_FF00)) : 32'h0000_0000;
		@(posedge pclk);
		penable <= 1'b1;
		// Hold the request until pready is seen high at a rising edge
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, {1'b0, e});
	endtask

	// Level checks are made at the falling edge, where registers have settled
	task automatic po(input int n, input logic [10:0] e);
		repeat (n) @(negedge pclk);
		chk("outputs", {22'h00_0000, e}, {22'h00_0000, outs});
	endtask

	task automatic wfor(input logic want);
		int n;
		n = 0;
		while (is_slow !== want && n < 3000)
		begin
			@(negedge pclk);
			n++;
		end
		chk("clock state", {32'h0000_0000, want}, {32'h0000_0000, is_slow});
	endtask

	// Answer watcher: every pready takes the oldest expected answer
	always @(negedge pclk)
		if (pready === 1'b1)
			chk("apb answer", exp_q.pop_front(), {pslverr, prdata});
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [2:0] i;
		logic [31:0] m;
		int          n;
		presetn = 0; pclk_en = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; power_down = 0; low_sup = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		po(1, 11'h7A0);
		rd(12'h040, 32'h0000_0080);
		rd(12'h044, 32'h0000_0003);
		// Unmapped places answer with error and leave the mode alone
		apb(1'b0, 12'h050, 32'h0000_0000, 33'h1_0000_0000);
		apb(1'b1, 12'h140, 32'h0000_0001, 33'h1_0000_0000);
		rd(12'h040, 32'h0000_0080);
		// Every timer source code; bit 3 written high must not stick
		for (i = 0; i < 4; i++)
		begin
			wr(12'h040, {24'h00_0000, 1'h1, i[0], i[1:0], 4'h8});
			po(2, {6'h3D, i[1:0], i[0], 2'h0});
			// Over eight cycles sys/4 gives two ticks and no source gives none
			n = 0;
			repeat (8)
			begin
				@(negedge pclk);
				n += t1clk;
			end
			if (i[0] == 1'b1)
				chk("prescaler ticks", i[1] ? 33'd0 : 33'd2, {1'b0, n[31:0]});
			rd(12'h040, {24'h00_0000, 1'h1, i[0], i[1:0], 4'h0});
		end
		wr(12'h040, 32'h0000_0084);
		po(2, 11'h5A0);
		wr(12'h040, 32'h0000_0000);
		po(2, 11'h6A0);
		rd(12'h040, 32'h0000_0000);
		wr(12'h040, 32'h0000_0080);
		wr(12'h044, 32'h0000_0000);
		po(2, 11'h700);
		rd(12'h044, 32'h0000_0000);
		wr(12'h044, 32'h0000_0003);
		// Random mask read back, then all masked
		m = {29'h0, seed[2:0]};
		wr(12'h04C, m);
		rd(12'h04C, m);
		wr(12'h04C, 32'h0000_0000);
		// Fast to slow: fast oscillator stops, masked event keeps irq low
		wr(12'h040, 32'h0000_0081);
		wfor(1'b1);
		po(4, 11'h3E2);
		wr(12'h04C, 32'h0000_0001);
		po(2, 11'h3E3);
		rd(12'h048, 32'h0000_0001);
		po(2, 11'h3E2);
		// Slow to fast: enable, then source back with enable auto-cleared
		wr(12'h040, 32'h0000_0083);
		po(4, 11'h7E2);
		rd(12'h040, 32'h0000_0083);
		wr(12'h040, 32'h0000_0082);
		wfor(1'b0);
		// The mux handover needs a few slow periods before the event is posted
		repeat (300) @(negedge pclk);
		po(4, 11'h7A0);
		rd(12'h040, 32'h0000_0080);
		rd(12'h048, 32'h0000_0002);
		// Low supply flag and its event
		@(posedge pclk);
		low_sup <= 1'b1;
		po(6, 11'h7A0);
		rd(12'h040, 32'h0000_0088);
		wr(12'h04C, 32'h0000_0004);
		po(2, 11'h7A1);
		rd(12'h048, 32'h0000_0004);
		@(posedge pclk);
		low_sup <= 1'b0;
		// Power-down stops only the fast oscillator; a low clock enable holds it off
		@(posedge pclk);
		pclk_en    <= 1'b0;
		power_down <= 1'b1;
		po(6, 11'h7A0);
		@(posedge pclk);
		pclk_en <= 1'b1;
		po(6, 11'h3A0);
		@(posedge pclk);
		power_down <= 1'b0;
		po(6, 11'h7A0);
		end_sim;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		end_sim;
	end
endmodule // testbench
`default_nettype wire
